// ---- src/asr_pkg.sv ----
/*
  Shared constants and carrier types for the byte-wide static memory host controller.
  Assumes a single 10 MHz clock with every timing count derived from its period.
*/
package asr_pkg;

  localparam int unsigned ADDR_W       = 21;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned WORDS        = 2097152;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned POWER_WAIT_US = 1000;
  localparam int unsigned POWER_WAIT_CYC =
    (POWER_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TURNOFF_NS   = 5;
  localparam int unsigned SETUP_NS     = 6;
  localparam int unsigned ACCESS_NS    = 12;
  localparam int unsigned TURNOFF_CYC  =
    ((TURNOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (TURNOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC    =
    ((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC   =
    ((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_LOW_CYC   = TURNOFF_CYC + SETUP_CYC;
  localparam int unsigned CNT_W        = 4;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 21'h000000;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_t;

  typedef struct packed {
    logic              select_low_active_n;
    logic              select_high_active;
    logic              out_en_n;
    logic              wr_en_n;
    logic [ADDR_W-1:0] addr;
  } asr_pins_t;

  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_IDLE  = 3'b001,
    ST_RSEL  = 3'b010,
    ST_RDATA = 3'b011,
    ST_WSET  = 3'b100,
    ST_WLOW  = 3'b101,
    ST_WEND  = 3'b110
  } asr_state_t;

endpackage

// ---- src/asr_power_wait.sv ----
/*
  Power-up wait counter for the static memory host.
  Assumes the supply is at its operating level when reset is released.
*/
module asr_power_wait
  import asr_pkg::*;
#(
  parameter int unsigned WAIT_CYC = POWER_WAIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      ready
);

  logic [15:0] cnt_q;

  // A wait of about ten thousand cycles is why this is a parameter for simulation.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      ready <= 1'b0;
    end else if (!ready) begin
      if (cnt_q >= 16'(WAIT_CYC - 1)) begin
        ready <= 1'b1;
      end
      cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule // asr_power_wait

// ---- src/asr_host.sv ----
/*
  Host controller that drives an asynchronous 2M x 8 static memory through its pins.
  Assumes the memory pins are wired directly and the bench resolves the shared byte lines.
*/
module asr_host
  import asr_pkg::*;
#(
  parameter int unsigned WAIT_CYC = POWER_WAIT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire asr_req_t          req,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output asr_pins_t              pins,
  input  wire logic [DATA_W-1:0] byte_lines_in,
  output logic [DATA_W-1:0]      byte_lines_out,
  output logic                   byte_lines_oe_n
);

  asr_state_t        state_q;
  asr_req_t          req_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              powered;
  logic              chip_sel_n;

  asr_power_wait #(
    .WAIT_CYC (WAIT_CYC)
  ) u_power (
    .clk   (clk),
    .rst_n (rst_n),
    .ready (powered)
  );

  // Requests are refused until the power-up wait has run out.
  assign req_ready = powered && (state_q == ST_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_POWER;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_POWER: begin
          if (powered) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (req_valid && req_ready) begin
            state_q <= req.write ? ST_WSET : ST_RSEL;
            cnt_q   <= '0;
          end
        end
        ST_RSEL: begin
          if (cnt_q == CNT_W'(ACCESS_CYC - 1)) begin
            state_q <= ST_RDATA;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RDATA: state_q <= ST_IDLE;
        ST_WSET: begin
          state_q <= ST_WLOW;
          cnt_q   <= '0;
        end
        ST_WLOW: begin
          // Held long enough for the memory to float and the data to settle.
          if (cnt_q == CNT_W'(WR_LOW_CYC - 1)) begin
            state_q <= ST_WEND;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WEND: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= '{write: 1'b0, addr: ADDR_RST, wdata: RDATA_RST};
    end else if (req_valid && req_ready) begin
      req_q <= req;
    end
  end

  // Select is held across the whole access and dropped one cycle after the
  // write enable rises, so write enable alone ends the write.
  assign chip_sel_n = !(state_q inside {ST_RSEL, ST_RDATA, ST_WSET, ST_WLOW});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins <= '{select_low_active_n: 1'b1, select_high_active: 1'b0,
                out_en_n: 1'b1, wr_en_n: 1'b1, addr: ADDR_RST};
    end else begin
      // Both selects move together from one combined condition.
      pins.select_low_active_n <= chip_sel_n;
      pins.select_high_active  <= !chip_sel_n;
      // Address comes from the incoming request on acceptance and from the latched request after, stable before select asserts.
      pins.addr <= (state_q == ST_IDLE && req_valid && req_ready) ? req.addr : req_q.addr;
      // Output enable is only asserted on reads; writes keep it high.
      pins.out_en_n <= !(state_q == ST_IDLE && req_valid && req_ready && !req.write) &&
                       !(state_q == ST_RSEL);
      pins.wr_en_n  <= !(state_q == ST_WSET || (state_q == ST_WLOW &&
                       cnt_q != CNT_W'(WR_LOW_CYC - 1)));
    end
  end

  // The host drives only between write setup and one cycle after the write ends,
  // so data holds across the ending edge. Reads never see the host driving.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_lines_oe_n <= 1'b1;
      byte_lines_out  <= RDATA_RST;
    end else begin
      byte_lines_oe_n <= !(state_q == ST_IDLE && req_valid && req_ready && req.write) &&
                         !(state_q inside {ST_WSET, ST_WLOW});
      if (state_q == ST_IDLE && req_valid && req_ready) begin
        byte_lines_out <= req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= RDATA_RST;
    end else begin
      // Read data is taken at the end of the last cycle with output enable low, once select has stood for
      // the whole access time; sampling earlier would catch an undriven bus.
      rsp_valid <= state_q inside {ST_RDATA, ST_WEND};
      if (state_q == ST_RDATA) begin
        rsp_rdata <= byte_lines_in;
      end
    end
  end

  sequence write_pulse_s;
    !pins.wr_en_n ##1 pins.wr_en_n;
  endsequence

  no_early_access_a: assert property (@(posedge clk) disable iff (!rst_n)
    !powered |-> pins.select_low_active_n && pins.wr_en_n && pins.out_en_n)
    else $error("Access started before power wait.");
  sel_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    pins.select_low_active_n == !pins.select_high_active)
    else $error("Selects disagree.");
  no_contention_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.out_en_n |-> byte_lines_oe_n)
    else $error("Host drives during read.");
  we_ends_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    write_pulse_s |-> !pins.select_low_active_n)
    else $error("Write not ended by write enable.");
  data_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    write_pulse_s |-> !byte_lines_oe_n && $stable(byte_lines_out))
    else $error("Write data not held at write end.");
  write_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.wr_en_n |-> !pins.select_low_active_n && !byte_lines_oe_n && pins.out_en_n)
    else $error("Write without select or data.");
  we_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.wr_en_n) |-> !pins.wr_en_n [*2])
    else $error("Write pulse too short.");
  addr_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.select_low_active_n && !$rose(!pins.select_low_active_n) |-> $stable(pins.addr))
    else $error("Address moved while selected.");
  read_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.out_en_n) |-> ##[1:3] rsp_valid)
    else $error("Read answer missing.");

endmodule // asr_host

// ---- tb/asr_sram_model.sv ----
/*
  Behavioural model of the byte-wide static memory that the host drives.
  Assumes the bench resolves the shared byte lines and feeds them back in.
*/
module asr_sram_model
  import asr_pkg::*;
(
  input  wire asr_pins_t         pins,
  input  wire logic [DATA_W-1:0] lines_in,
  output logic [DATA_W-1:0]      lines_out,
  output logic                   drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic                 sel;
  logic                 wr_act;
  logic [DATA_W-1:0]    wlat;
  logic [ADDR_W-1:0]    alat;
  logic [DATA_W-1:0]    mem [logic [ADDR_W-1:0]];
  assign sel    = !pins.select_low_active_n && pins.select_high_active;
  assign wr_act = sel && !pins.wr_en_n;
  assign drive  = sel && !pins.out_en_n && pins.wr_en_n;
  always @(pins or wr_act) begin
    lines_out = mem.exists(pins.addr) ? mem[pins.addr] : 8'h00;
  end
  // Data is latched during the interval so the store uses what stood before the ending edge.
  always @(lines_in or wr_act or pins) begin
    if (wr_act) begin
      wlat = lines_in;
      alat = pins.addr;
    end
  end
  always @(negedge wr_act) begin
    mem[alat] = wlat;
  end
endmodule // asr_sram_model

// ---- tb/async_sram_2m_by_8_test.sv ----
/*
  Self-checking bench for the static memory host controller.
  Assumes the memory model above stands on the far side of the pins.
*/
module async_sram_2m_by_8_test
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned WAIT = 20;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_ready, rsp_valid;
  asr_req_t          req = '0;
  asr_pins_t         pins;
  logic [DATA_W-1:0] rsp_rdata, host_out, mdl_out, lines, last_v = 8'h00;
  logic              host_oe_n, mdl_drv;
  logic              prev_sel_n = 1'b1;
  logic [ADDR_W-1:0] prev_addr  = '0;
  int                errors = 0, checked = 0, cycles = 0;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  // Undriven lines show the inverse of the last value so a stale byte never passes.
  assign lines = !host_oe_n ? host_out : (mdl_drv ? mdl_out : ~last_v);
  asr_host #(.WAIT_CYC(WAIT)) dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .pins(pins), .byte_lines_in(lines), .byte_lines_out(host_out),
    .byte_lines_oe_n(host_oe_n));
  asr_sram_model mdl (.pins(pins), .lines_in(lines), .lines_out(mdl_out), .drive(mdl_drv));
  always #50 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
    if (!host_oe_n) last_v <= host_out;
    else if (mdl_drv) last_v <= mdl_out;
  end
  always @(negedge clk) begin
    if (rst_n) begin
      check({31'h0, !host_oe_n && mdl_drv}, 32'h0, "bus contention");
      if (!pins.wr_en_n) check({31'h0, !host_oe_n}, 32'h1, "write data not driven");
      // The address must be stable across every selected interval.
      if (!prev_sel_n && !pins.select_low_active_n)
        check(pins.addr, prev_addr, "address moved while selected");
    end
    prev_sel_n <= pins.select_low_active_n;
    prev_addr  <= pins.addr;
  end
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{write: wr, addr: a, wdata: d};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    check(n, wr ? WR_LOW_CYC + 3 : ACCESS_CYC + 2, "answer latency");
    if (wr) shadow[a] = d;
    else check(rsp_rdata, shadow[a], "read data");
  endtask
  task automatic t_power();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
      check({pins.select_low_active_n, pins.select_high_active}, 2'b10, "select early");
    end
    check({31'h0, n >= WAIT}, 32'h1, "power wait too short");
  endtask
  task automatic t_rw();
    logic [ADDR_W-1:0] addrs [4] = '{21'h000000, 21'h1FFFFF, 21'h0AAAAA, 21'h155555};
    for (int i = 0; i < 4; i++) access(1'b1, addrs[i], 8'h5A ^ 8'(i * 8'h33));
    for (int i = 0; i < 4; i++) access(1'b0, addrs[i], 8'h00);
    access(1'b1, 21'h1FFFFF, 8'hC3);
    access(1'b0, 21'h1FFFFF, 8'h00);
    access(1'b0, 21'h000000, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_rw();
    finish_test();
  end
endmodule // async_sram_2m_by_8_test
